//--- core/dsi3_address_assignment.sv
// Notes on behaviour
// RQ1: A falling receive comparator output marks the start of a master command.
// RQ2: Comparator low time is counted on the clock; decoding uses that count.
// RQ3: Non-zero one-time address skips all other assignment and waits for configuration.
// RQ4: Pre-programmed device keeps bus switch open until configuration closes it.
// RQ5: Unaddressed device accepts global write to address zero setting non-zero address; the code takes it only in S_STARTUP or S_LISTEN.
// RQ6: Downstream bus switch is off after power-up.
// RQ7: Listen for discovery only with init flag clear, address zero, after delay.
// RQ8: After reply delay, unaddressed devices ramp reply current toward twice unit.
// RQ9: Downstream current above unit: reply off, counter up, wait next discovery.
// RQ10: With low downstream current, finish ramp in ramp time and hold full level.
// RQ11: No downstream current by hold end after first command: take address one.
// RQ12: Later commands repeat the sequence and adopt the counter value as address.
// RQ13: The master powers the segment and starts discovery itself.
// RQ14: The master repeats discovery at the period, once per expected device.
// RQ15: After discovery, further set-up uses command/response with the new address.
// RQ16: A frame is acted on only if its address equals the bus address.
// RQ17: The discovery address counter starts at one after reset.
`timescale 1ns/1ps
`default_nettype none

module dsi3_address_assignment #(
	parameter int unsigned LISTEN_CYCLES = dsi3_addr_pkg::LISTEN_DELAY_CYCLES,
	parameter int unsigned REPLY_CYCLES  = dsi3_addr_pkg::REPLY_DELAY_CYCLES,
	parameter int unsigned RAMP_CYCLES   = dsi3_addr_pkg::RAMP_TIME_CYCLES,
	parameter int unsigned HOLD_CYCLES   = dsi3_addr_pkg::HOLD_TIME_CYCLES,
	parameter int unsigned CMD_MIN       = dsi3_addr_pkg::CMD_MIN_CYCLES,
	parameter int unsigned CMD_MAX       = dsi3_addr_pkg::CMD_MAX_CYCLES
) (
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic                      command_detect_n,
	input  wire logic                      sense_above_unit,
	input  wire logic [3:0]                otp_address,
	input  wire dsi3_addr_pkg::frame_t     frame,
	input  wire dsi3_addr_pkg::avalon_req_t avs,
	output logic                           avs_waitrequest,
	output logic [31:0]                    avs_readdata,
	output logic                           bus_switch_on,
	output logic                           reply_enable,
	output logic [7:0]                     reply_level,
	output logic [3:0]                     bus_address,
	output logic                           command_start,
	output logic                           discovery_seen,
	output logic                           frame_accept
);
	import dsi3_addr_pkg::*;

	localparam int unsigned STEP_RAW   = RAMP_CYCLES / 255;
	localparam int unsigned STEP_CYCLES = (STEP_RAW < 1) ? 1 : STEP_RAW;

	// Every delay count must fit the 24-bit timer, the command window the 16-bit low counter; all at least one cycle
	if (LISTEN_CYCLES < 1 || LISTEN_CYCLES >= 2**24 || REPLY_CYCLES < 1 ||
		REPLY_CYCLES >= 2**24 || HOLD_CYCLES < 1 || HOLD_CYCLES >= 2**24 ||
		RAMP_CYCLES < 1 || RAMP_CYCLES >= 2**24 || CMD_MIN < 1 ||
		CMD_MAX < CMD_MIN || CMD_MAX >= 2**16) begin : g_bad_param
		$error("dsi3_address_assignment: timing parameter out of range");
	end

	typedef struct packed {
		logic [1:0]  cmd_sync;
		logic [1:0]  sense_sync;
		logic [3:0]  otp_s1;
		logic [3:0]  otp_s2;
		logic        cmd_prev;
		logic [15:0] low_count;
		disc_state_t state;
		logic [23:0] timer;
		logic [7:0]  ramp;
		logic [3:0]  addr;
		logic [3:0]  addr_count;
		logic        init_done;
		logic        switch_req;
		logic        switch_on;
		logic        reply_on;
		logic        start_pulse;
		logic        disc_pulse;
		logic        accept;
		logic        wait_q;
		logic [31:0] rdata;
	} core_state_t;

	core_state_t q;
	core_state_t d;
	logic        cmd_level;
	logic        sense_level;
	logic        disc_event;
	logic        off_now;

	// Only the second synchroniser stage is looked at
	assign cmd_level   = q.cmd_sync[1];
	assign sense_level = q.sense_sync[1];

	// Discovery command: a low pulse whose length falls in the window
	assign disc_event = cmd_level && !q.cmd_prev &&
		(q.low_count >= 16'(CMD_MIN)) && (q.low_count <= 16'(CMD_MAX)); // RQ2

	// Downstream current seen while we source current means someone below is louder
	assign off_now = q.reply_on && sense_level; // RQ9

	// Next state of the whole block
	always_comb begin
		d = q;
		d.start_pulse = 1'b0;
		d.disc_pulse  = 1'b0;
		d.accept      = 1'b0;
		d.cmd_sync    = {q.cmd_sync[0], command_detect_n};
		d.sense_sync  = {q.sense_sync[0], sense_above_unit};
		d.otp_s1      = otp_address;
		d.otp_s2      = q.otp_s1;
		d.cmd_prev    = cmd_level;

		// Command start and low-time counter
		if (q.cmd_prev && !cmd_level) begin
			d.start_pulse = 1'b1; // RQ1
		end
		if (cmd_level) begin
			d.low_count = 16'h0000;
		end else if (q.low_count != 16'hFFFF) begin
			d.low_count = q.low_count + 16'h0001; // RQ2
		end
		d.disc_pulse = disc_event;

		case (q.state)
			S_STRAP: begin
				// Wait for the strap to pass its synchroniser
				d.timer = q.timer + 24'h000001;
				if (q.timer == 24'h000002) begin
					d.timer = 24'h000000;
					if (q.otp_s2 != ADDRESS_NONE) begin
						d.addr  = q.otp_s2; // RQ3
						d.state = S_ADDRESSED;
					end else begin
						d.state = S_STARTUP;
					end
				end
			end
			S_STARTUP: begin
				d.timer = q.timer + 24'h000001;
				if (q.timer == 24'(LISTEN_CYCLES - 1)) begin
					d.timer = 24'h000000;
					d.state = S_LISTEN; // RQ7
				end
			end
			S_LISTEN: begin
				if (q.addr != ADDRESS_NONE || q.init_done) begin
					d.state = S_ADDRESSED; // RQ15
				end else if (disc_event) begin
					d.timer = 24'h000000;
					d.state = S_REPLY_DELAY; // RQ7
				end
			end
			S_REPLY_DELAY: begin
				d.timer = q.timer + 24'h000001;
				if (q.timer == 24'(REPLY_CYCLES - 1)) begin
					d.timer    = 24'h000000;
					d.reply_on = 1'b1; // RQ8
					d.ramp     = 8'h00;
					d.state    = S_RAMP;
				end
			end
			S_RAMP: begin
				d.timer = q.timer + 24'h000001;
				if (q.timer == 24'(STEP_CYCLES - 1)) begin
					// Even steps so full scale lands inside the ramp time
					d.timer = 24'h000000;
					d.ramp  = q.ramp + 8'h01; // RQ8
					if (q.ramp == REPLY_FULL_CODE - 8'h01) begin
						d.state = S_HOLD; // RQ10
					end
				end
			end
			S_HOLD: begin
				d.timer = q.timer + 24'h000001;
				if (q.timer == 24'(HOLD_CYCLES - 1)) begin
					// Counter is one on the first round, so the quiet winner takes one
					d.addr     = q.addr_count; // RQ11 RQ12
					d.reply_on = 1'b0;
					d.ramp     = 8'h00;
					d.timer    = 24'h000000;
					d.state    = S_ADDRESSED;
				end
			end
			S_ADDRESSED: begin
				d.state = S_ADDRESSED;
			end
			default: begin
				d.state = S_STRAP;
			end
		endcase

		// Back off as soon as a downstream slave outshouts us
		if (off_now) begin
			d.reply_on   = 1'b0; // RQ9
			d.ramp       = 8'h00;
			d.timer      = 24'h000000;
			d.addr_count = q.addr_count + 4'h1;
			d.addr       = q.addr; // A late loser must not keep the hold-end address
			d.state      = S_LISTEN;
		end

		// Frame address filter and global address write
		if (frame.valid) begin
			if (q.addr != ADDRESS_NONE && frame.address == q.addr) begin
				d.accept = 1'b1; // RQ16
			end else if (q.addr == ADDRESS_NONE && frame.address == ADDRESS_NONE &&
				frame.set_address && frame.new_address != ADDRESS_NONE &&
				(q.state == S_STARTUP || q.state == S_LISTEN)) begin
				d.addr   = frame.new_address; // RQ5
				d.accept = 1'b1;
			end
		end

		// Switch closes only on configuration and never while unaddressed
		d.switch_on = q.switch_req && (q.addr != ADDRESS_NONE); // RQ4 RQ6

		// Avalon slave: one wait cycle, then the access completes
		if (q.wait_q && (avs.read || avs.write)) begin
			d.wait_q = 1'b0;
			case (avs.address)
				CTRL_OFFSET:   d.rdata = {30'h0, q.switch_req, q.init_done};
				STATUS_OFFSET: d.rdata = {16'h0, 1'b0, q.state, q.switch_on, q.reply_on,
					2'b00, q.addr_count, q.addr};
				default:       d.rdata = 32'h00000000;
			endcase
		end else begin
			d.wait_q = 1'b1;
		end
		if (!q.wait_q && avs.write && avs.byteenable[0] && avs.address == CTRL_OFFSET) begin
			d.init_done  = avs.writedata[CTRL_INIT_BIT];
			d.switch_req = avs.writedata[CTRL_SWITCH_BIT]; // RQ4
		end
	end

	// State register; reset leaves switch open and counter at one
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			q            <= '0;
			q.cmd_sync   <= 2'b11;
			q.cmd_prev   <= 1'b1;
			q.state      <= S_STRAP;
			q.addr_count <= COUNTER_RESET; // RQ17
			q.switch_on  <= 1'b0; // RQ6
			q.wait_q     <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state flops
	assign avs_waitrequest = q.wait_q;
	assign avs_readdata    = q.rdata;
	assign bus_switch_on   = q.switch_on;
	assign reply_enable    = q.reply_on;
	assign reply_level     = q.ramp;
	assign bus_address     = q.addr;
	assign command_start   = q.start_pulse;
	assign discovery_seen  = q.disc_pulse;
	assign frame_accept    = q.accept;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_start_on_fall: assert property ($fell(cmd_level) |=> command_start) // RQ1
		else $error("command start not flagged after comparator fall");
	a_low_count_up: assert property ((!cmd_level && q.low_count < 16'h0FFF)
		|=> q.low_count == $past(q.low_count) + 16'h0001) // RQ2
		else $error("low-time counter did not advance");
	a_strap_skips: assert property ((q.state == S_STRAP && q.timer == 24'h000002 &&
		q.otp_s2 != ADDRESS_NONE) |=> (q.state == S_ADDRESSED &&
		bus_address == $past(q.otp_s2))) // RQ3
		else $error("stored address did not bypass discovery");
	a_switch_address: assert property (bus_switch_on |-> $past(bus_address) != ADDRESS_NONE) // RQ4
		else $error("bus switch closed without an address");
	a_global_write: assert property ((frame.valid && bus_address == ADDRESS_NONE &&
		frame.address == ADDRESS_NONE && frame.set_address &&
		frame.new_address != ADDRESS_NONE && q.state == S_LISTEN && !off_now)
		|=> (frame_accept && bus_address == $past(frame.new_address))) // RQ5
		else $error("global address write not taken");
	a_listen_gated: assert property ((q.state == S_LISTEN ##1 q.state == S_REPLY_DELAY)
		|-> ($past(bus_address) == ADDRESS_NONE && !$past(q.init_done))) // RQ7
		else $error("discovery answered while addressed or initialised");
	a_ramp_origin: assert property ($rose(reply_enable) |-> $past(q.state) == S_REPLY_DELAY) // RQ8
		else $error("reply current started outside the reply delay");
	a_sense_backoff: assert property (off_now |=> (!reply_enable &&
		q.addr_count == $past(q.addr_count) + 4'h1 && q.state == S_LISTEN &&
		bus_address == $past(bus_address))) // RQ9
		else $error("no back-off on downstream current");
	a_hold_full: assert property ((q.state == S_HOLD && !off_now) |-> reply_level == REPLY_FULL_CODE) // RQ10
		else $error("hold level is not full scale");
	a_adopt_counter: assert property ((q.state == S_HOLD && q.timer == 24'(HOLD_CYCLES - 1) &&
		!off_now) |=> (bus_address == $past(q.addr_count) && !reply_enable)) // RQ11
		else $error("counter value not adopted at hold end");
	a_frame_match: assert property (frame_accept |-> ($past(frame.address) == $past(bus_address)
		|| $past(bus_address) == ADDRESS_NONE)) // RQ16
		else $error("frame accepted for a foreign address");
	a_counter_start: assert property (q.state == S_STARTUP |-> q.addr_count == COUNTER_RESET) // RQ17
		else $error("address counter not one before discovery");

	c_won_address: cover property (q.state == S_HOLD ##1 q.state == S_ADDRESSED);
	c_backed_off:  cover property (off_now);
	c_global_set:  cover property (frame_accept && $past(bus_address) == ADDRESS_NONE);
	c_switch_on:   cover property ($rose(bus_switch_on));

endmodule // dsi3_address_assignment

`default_nettype wire

//--- pkg/dsi3_addr_pkg.sv
`default_nettype none

package dsi3_addr_pkg;

	// Clock figures
	localparam int unsigned CLOCK_HZ        = 25_000_000;
	localparam int unsigned CLOCK_PERIOD_NS = 40;

	// Discovery timing in its own unit (ns)
	localparam int unsigned DISCOVERY_LISTEN_DELAY_NS = 1_000_000;
	localparam int unsigned DISCOVERY_REPEAT_PERIOD_NS = 2_000_000;
	localparam int unsigned DISCOVERY_REPLY_DELAY_NS  = 20_000;
	localparam int unsigned DISCOVERY_RAMP_TIME_NS    = 40_000;
	localparam int unsigned DISCOVERY_HOLD_TIME_NS    = 40_000;
	localparam int unsigned DISCOVERY_CMD_MIN_NS      = 8_000;
	localparam int unsigned DISCOVERY_CMD_MAX_NS      = 40_000;

	// Cycle counts: least times round up, longest times round down
	localparam int unsigned LISTEN_DELAY_CYCLES =
		(DISCOVERY_LISTEN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned REPEAT_PERIOD_CYCLES =
		(DISCOVERY_REPEAT_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned REPLY_DELAY_CYCLES =
		(DISCOVERY_REPLY_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned RAMP_TIME_CYCLES = DISCOVERY_RAMP_TIME_NS / CLOCK_PERIOD_NS;
	localparam int unsigned HOLD_TIME_CYCLES =
		(DISCOVERY_HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned CMD_MIN_CYCLES =
		(DISCOVERY_CMD_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned CMD_MAX_CYCLES = DISCOVERY_CMD_MAX_NS / CLOCK_PERIOD_NS;

	// Reply current codes: full scale is twice the unit reply current
	localparam logic [7:0] REPLY_FULL_CODE = 8'hFF;
	localparam logic [7:0] REPLY_UNIT_CODE = 8'h80;
	localparam logic [3:0] ADDRESS_NONE    = 4'h0;
	localparam logic [3:0] COUNTER_RESET   = 4'h1;

	// Register map (byte addresses)
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam int unsigned CTRL_INIT_BIT   = 0;
	localparam int unsigned CTRL_SWITCH_BIT = 1;

	typedef enum logic [2:0] {
		S_STRAP,
		S_STARTUP,
		S_LISTEN,
		S_REPLY_DELAY,
		S_RAMP,
		S_HOLD,
		S_ADDRESSED
	} disc_state_t;

	// Command/response frame as handed over by the frame decoder
	typedef struct packed {
		logic       valid;
		logic [3:0] address;
		logic       set_address;
		logic [3:0] new_address;
	} frame_t;

	// Avalon-MM slave request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avalon_req_t;

endpackage

`default_nettype wire

//--- test/dsi3_address_assignment_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

module dsi3_address_assignment_tb;
	import dsi3_addr_pkg::*;
	localparam int unsigned LISTEN = 20;
	logic        clock, reset, sense, send, cmd_n, wreq, sw, ren, cs, ds, fa;
	logic [7:0]  low_len, lvl, peak;
	logic [3:0]  otp, addr, na;
	logic [31:0] rdata, q;
	frame_t      frame;
	avalon_req_t avs;
	int          fail_count, tests_run, cs_n, ds_n, fa_n, k;

	dsi3_master_model dsi3_master_model_inst (.clock(clock), .reset(reset), .send(send),
		.low_len(low_len), .command_detect_n(cmd_n));
	dsi3_address_assignment #(.LISTEN_CYCLES(LISTEN), .REPLY_CYCLES(4), .RAMP_CYCLES(255),
		.HOLD_CYCLES(8), .CMD_MIN(4), .CMD_MAX(40)) dsi3_address_assignment_inst (
		.clock(clock), .reset(reset), .command_detect_n(cmd_n), .sense_above_unit(sense),
		.otp_address(otp), .frame(frame), .avs(avs), .avs_waitrequest(wreq),
		.avs_readdata(rdata), .bus_switch_on(sw), .reply_enable(ren), .reply_level(lvl),
		.bus_address(addr), .command_start(cs), .discovery_seen(ds), .frame_accept(fa));

	// Clock and pulse counters
	always #20 clock = ~clock;
	always @(negedge clock) begin
		cs_n += (cs === 1'b1);
		ds_n += (ds === 1'b1);
		fa_n += (fa === 1'b1);
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [3:0] o);
		reset <= 1'b1;
		otp <= o;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		repeat (LISTEN + 10) @(posedge clock);
	endtask

	// One Avalon transfer: held until waitrequest is seen low at an edge
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs <= '{!wr, wr, a, 4'hF, d};
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (wreq === 1'b0) break;
		end
		if (n == 50) begin
			fail_count++;
			wrap_up();
		end
		q = rdata;
		avs <= '0;
	endtask

	task automatic disc(input logic [7:0] len);
		@(posedge clock);
		send <= 1'b1;
		low_len <= len;
		@(posedge clock);
		send <= 1'b0;
		repeat (int'(len) + 6) @(posedge clock);
	endtask

	task automatic send_frame(input logic [3:0] a, input logic s, input logic [3:0] n);
		@(posedge clock);
		frame <= '{1'b1, a, s, n};
		@(posedge clock);
		frame <= '0;
		repeat (3) @(posedge clock);
	endtask

	// Discovery round; downstream current shows up once the ramp starts if hi
	task automatic round(input logic hi);
		logic on;
		int   d0;
		on = 1'b0;
		peak = 8'h00;
		d0 = ds_n;
		disc(8'd8);
		for (k = 0; k < 800 && !(on && ren === 1'b0); k++) begin
			@(negedge clock);
			if (ren === 1'b1) begin
				on = 1'b1;
				if (lvl > peak) peak = lvl;
			end
			@(posedge clock);
			sense <= hi && on;
		end
		`CHK("reply on", 1'b1, on)
		`CHK("disc seen", 1, ds_n - d0)
		if (k == 800) begin
			fail_count++;
			wrap_up();
		end
		sense <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	initial begin
		clock = 0; reset = 1; sense = 0; send = 0; low_len = 0; otp = 0;
		frame = '0; avs = '0; fail_count = 0; tests_run = 0; cs_n = 0; ds_n = 0; fa_n = 0;
		void'($urandom(11491));
		do_reset(4'h0);
		`CHK("switch", 1'b0, sw)
		xfer(1'b0, STATUS_OFFSET, 32'h0);
		`CHK("counter", COUNTER_RESET, q[7:4])
		xfer(1'b0, 4'hC, 32'h0);
		`CHK("unmapped", 32'h0, q)
		k = ds_n;
		disc(8'd2);
		`CHK("cmd start", 1, cs_n)
		`CHK("short pulse", k, ds_n)
		round(1'b0);
		`CHK("peak", REPLY_FULL_CODE, peak)
		`CHK("first addr", 4'h1, addr)
		for (int i = 0; i < 12; i++) begin
			na = (i < 2) ? 4'(i) : 4'($urandom_range(15));
			k = fa_n;
			send_frame(na, 1'b0, 4'h0);
			`CHK("accept", (na == 4'h1), fa_n - k)
		end
		disc(8'd8);
		repeat (20) @(posedge clock);
		`CHK("no relisten", 1'b0, ren)
		do_reset(4'h0);
		round(1'b1);
		`CHK("lost addr", 4'h0, addr)
		xfer(1'b0, STATUS_OFFSET, 32'h0);
		`CHK("counter up", 4'h2, q[7:4])
		round(1'b0);
		`CHK("second addr", 4'h2, addr)
		na = 4'($urandom_range(14) + 1);
		do_reset(na);
		`CHK("otp addr", na, addr)
		disc(8'd8);
		repeat (20) @(posedge clock);
		`CHK("otp no disc", 1'b0, ren)
		`CHK("switch open", 1'b0, sw)
		xfer(1'b1, CTRL_OFFSET, 32'h2);
		repeat (3) @(posedge clock);
		`CHK("switch closed", 1'b1, sw)
		do_reset(4'h0);
		xfer(1'b1, CTRL_OFFSET, 32'h1);
		xfer(1'b0, CTRL_OFFSET, 32'h0);
		`CHK("init flag", 32'h1, q)
		disc(8'd8);
		repeat (20) @(posedge clock);
		`CHK("init no disc", 1'b0, ren)
		`CHK("init no addr", 4'h0, addr)
		do_reset(4'h0);
		na = 4'($urandom_range(14) + 1);
		send_frame(4'h0, 1'b1, na);
		`CHK("global write", na, addr)
		k = fa_n;
		send_frame(na, 1'b0, 4'h0);
		`CHK("new addr frame", 1, fa_n - k)
		wrap_up();
	end

	// Watchdog cuts a hang short
	initial begin
		repeat (100000) @(posedge clock);
		fail_count++;
		wrap_up();
	end
endmodule // dsi3_address_assignment_tb

`default_nettype wire

//--- test/dsi3_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master side: drives the receive comparator level for one command
module dsi3_master_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       send,
	input  wire logic [7:0] low_len,
	output logic            command_detect_n
);
	logic [7:0] low_q;

	// A command starts on send while the bus is idle and holds the level low for low_len cycles
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			low_q <= 8'h00;
		end else if (send && low_q == 8'h00) begin
			low_q <= low_len;
		end else if (low_q != 8'h00) begin
			low_q <= low_q - 8'h01;
		end
	end

	// Bus rests at the high level between commands
	assign command_detect_n = (low_q == 8'h00);
endmodule // dsi3_master_model

`default_nettype wire
